// File: sfdp_basic_param_rom.sv
/*
  Parameter-space read responder: decodes the serial read-parameter command,
  streams table bytes MSB first, and exposes control and status over AHB-Lite.
  Assumes serial mode 0, a serial clock well below a quarter of clk, and a
  chip select that falls at least two clk cycles before the first serial edge.
*/
// Implementation choices: the AHB-Lite slave port and the register addresses.
module sfdp_basic_param_rom
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire sfdp_pkg::spi_in_t spi_in,
  output logic miso_o,
  output logic miso_oe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  sfdp_pkg::spi_in_t sync1_reg;
  sfdp_pkg::spi_in_t sync2_reg;
  logic sclk_prev_reg;
  sfdp_pkg::link_state_t state_reg;
  logic [4:0] bit_cnt_reg;
  logic [2:0] out_cnt_reg;
  logic [23:0] shift_reg;
  logic [23:0] addr_reg;
  logic [7:0] tx_reg;
  logic miso_reg;
  logic oe_reg;
  logic [15:0] byte_count_reg;
  logic [31:0] ctrl_reg;
  logic [7:0] lookup_addr_reg;
  sfdp_pkg::bus_req_t req_reg;
  logic rd_done_reg;
  logic [31:0] hrdata_reg;

  // Pure constant lookup: no storage, so nothing on the bus or link can alter it
  // Addresses outside the served bytes read all ones, like erased parameter space
  function automatic logic [7:0] table_byte(input logic [23:0] a);
    logic [7:0] v;
    v = sfdp_pkg::VAL_ALL_ONES;
    case (a)
      sfdp_pkg::ADDR_HDR_LENGTH: v = sfdp_pkg::HDR_LENGTH_DWORDS;
      sfdp_pkg::ADDR_HDR_POINTER: v = sfdp_pkg::TABLE_BASE;
      sfdp_pkg::ADDR_ERASE_INFO: v = sfdp_pkg::VAL_ERASE_INFO;
      sfdp_pkg::ADDR_ERASE_OP: v = sfdp_pkg::VAL_ERASE_OP;
      sfdp_pkg::ADDR_READ_SUPPORT: v = sfdp_pkg::VAL_READ_SUPPORT;
      sfdp_pkg::ADDR_DW1_TOP: v = sfdp_pkg::VAL_ALL_ONES;
      sfdp_pkg::ADDR_DENSITY_B0: v = sfdp_pkg::VAL_ALL_ONES;
      sfdp_pkg::ADDR_DENSITY_B1: v = sfdp_pkg::VAL_ALL_ONES;
      sfdp_pkg::ADDR_DENSITY_B2: v = sfdp_pkg::VAL_ALL_ONES;
      sfdp_pkg::ADDR_DENSITY_B3: v = sfdp_pkg::VAL_DENSITY_TOP;
      sfdp_pkg::ADDR_QUAD_IO_READ_CYCLES: v = sfdp_pkg::VAL_QUAD_IO_READ_CYCLES;
      sfdp_pkg::ADDR_QUAD_IO_READ_OP: v = sfdp_pkg::VAL_QUAD_IO_READ_OP;
      sfdp_pkg::ADDR_QUAD_OUTPUT_READ_CYCLES: v = sfdp_pkg::VAL_QUAD_OUTPUT_READ_CYCLES;
      sfdp_pkg::ADDR_QUAD_OUTPUT_READ_OP: v = sfdp_pkg::VAL_QUAD_OUTPUT_READ_OP;
      sfdp_pkg::ADDR_DUAL_OUTPUT_READ_CYCLES: v = sfdp_pkg::VAL_DUAL_OUTPUT_READ_CYCLES;
      sfdp_pkg::ADDR_DUAL_OUTPUT_READ_OP: v = sfdp_pkg::VAL_DUAL_OUTPUT_READ_OP;
      sfdp_pkg::ADDR_DUAL_IO_READ_CYCLES: v = sfdp_pkg::VAL_DUAL_IO_READ_CYCLES;
      default: v = sfdp_pkg::VAL_ALL_ONES;
    endcase
    return v;
  endfunction

  wire sclk_rise = sync2_reg.sclk & ~sclk_prev_reg;
  wire sclk_fall = ~sync2_reg.sclk & sclk_prev_reg;
  wire cs_active = ~sync2_reg.cs_n;
  wire [23:0] shift_next = {shift_reg[22:0], sync2_reg.mosi};
  wire cmd_ok = (shift_next[7:0] == sfdp_pkg::OP_READ_PARAM) & ctrl_reg[sfdp_pkg::CTRL_ENABLE_BIT];
  wire [7:0] link_byte = table_byte(addr_reg);
  wire [7:0] lookup_byte = table_byte({16'h0000, lookup_addr_reg});

  // Only the second stage is looked at; the first may be metastable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      // Idle pin levels (select high, clock low), so no false frame follows reset
      sync1_reg <= 3'h2;
      sync2_reg <= 3'h2;
      sclk_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      sync1_reg <= spi_in;
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg.sclk;
    end
  end

  // Link sequencer: opcode, three address bytes, eight dummy bits, then data
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= sfdp_pkg::ST_IDLE;
      bit_cnt_reg <= 5'h00;
      out_cnt_reg <= 3'h0;
      shift_reg <= 24'h000000;
      addr_reg <= 24'h000000;
      tx_reg <= 8'h00;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
      byte_count_reg <= 16'h0000;
    end
    else if (ce)
    begin
      if (!cs_active)
      begin
        state_reg <= sfdp_pkg::ST_IDLE;
        bit_cnt_reg <= 5'h00;
        oe_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          sfdp_pkg::ST_IDLE:
          begin
            state_reg <= sfdp_pkg::ST_CMD;
            bit_cnt_reg <= 5'h00;
          end
          sfdp_pkg::ST_CMD:
          begin
            if (sclk_rise)
            begin
              shift_reg <= shift_next;
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == sfdp_pkg::CMD_LAST)
              begin
                // Other opcodes are left to the rest of the device
                state_reg <= cmd_ok ? sfdp_pkg::ST_ADDR : sfdp_pkg::ST_IGNORE;
                bit_cnt_reg <= 5'h00;
              end
            end
          end
          sfdp_pkg::ST_ADDR:
          begin
            if (sclk_rise)
            begin
              shift_reg <= shift_next;
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == sfdp_pkg::ADDR_LAST)
              begin
                addr_reg <= shift_next;
                state_reg <= sfdp_pkg::ST_DUMMY;
                bit_cnt_reg <= 5'h00;
              end
            end
          end
          sfdp_pkg::ST_DUMMY:
          begin
            if (sclk_rise)
            begin
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == sfdp_pkg::DUMMY_LAST)
              begin
                state_reg <= sfdp_pkg::ST_DATA;
                bit_cnt_reg <= 5'h00;
                out_cnt_reg <= 3'h0;
              end
            end
          end
          sfdp_pkg::ST_DATA:
          begin
            if (sclk_fall)
            begin
              oe_reg <= 1'b1;
              out_cnt_reg <= out_cnt_reg + 3'h1;
              if (out_cnt_reg == 3'h0)
              begin
                miso_reg <= link_byte[7];
                tx_reg <= {link_byte[6:0], 1'b0};
                addr_reg <= addr_reg + 24'h000001;
                byte_count_reg <= byte_count_reg + 16'h0001;
              end
              else
              begin
                miso_reg <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
              end
            end
          end
          sfdp_pkg::ST_IGNORE:
          begin
            state_reg <= sfdp_pkg::ST_IGNORE;
          end
          default:
          begin
            state_reg <= sfdp_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  assign miso_o = miso_reg;
  assign miso_oe = oe_reg;

  // Bus slave: writes complete with no wait, reads take one wait state
  wire addr_phase = hsel & hready & htrans[sfdp_pkg::HTRANS_ACTIVE_BIT];
  wire rd_pending = req_reg.sel & ~req_reg.write;
  wire wr_commit = req_reg.sel & req_reg.write & hready;
  wire [31:0] status_word = {addr_reg, 4'h0, state_reg, cs_active};
  wire sel_ctrl = req_reg.addr == sfdp_pkg::REG_CTRL;
  wire sel_status = req_reg.addr == sfdp_pkg::REG_STATUS;
  wire sel_lookup_addr = req_reg.addr == sfdp_pkg::REG_LOOKUP_ADDR;
  wire sel_lookup_data = req_reg.addr == sfdp_pkg::REG_LOOKUP_DATA;
  wire sel_count = req_reg.addr == sfdp_pkg::REG_BYTE_COUNT;
  wire [31:0] rdata =
    sel_ctrl ? ctrl_reg :
    sel_status ? status_word :
    sel_lookup_addr ? {24'h000000, lookup_addr_reg} :
    sel_lookup_data ? {24'h000000, lookup_byte} :
    sel_count ? {16'h0000, byte_count_reg} :
    32'h00000000;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      req_reg <= '0;
      rd_done_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
    end
    else if (ce)
    begin
      if (hready)
      begin
        req_reg <= addr_phase ? {1'b1, hwrite, haddr[7:0]} : '0;
        rd_done_reg <= 1'b0;
      end
      else if (rd_pending)
      begin
        hrdata_reg <= rdata;
        rd_done_reg <= 1'b1;
      end
    end
  end

  // Table bytes have no write path; a write to the data window is dropped
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_reg <= sfdp_pkg::CTRL_RESET;
      lookup_addr_reg <= 8'h00;
    end
    else if (ce && wr_commit)
    begin
      if (sel_ctrl)
      begin
        ctrl_reg <= {31'h00000000, hwdata[sfdp_pkg::CTRL_ENABLE_BIT]};
      end
      if (sel_lookup_addr)
      begin
        lookup_addr_reg <= hwdata[7:0];
      end
    end
  end

  assign hreadyout = ~(rd_pending & ~rd_done_reg);
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

endmodule

// File: sfdp_pkg.sv
/*
  Constants and types for the serial link, register map and table of the discoverable-parameter ROM
  that serves the first four doublewords, less byte 3Fh, of the basic flash parameter table.
  Assumes a single 100 MHz system clock samples every serial-link pin.
*/
// Functional notes
// - Relative byte 30h returns E5h: uniform 4-KB erase, non-volatile status, big buffer.
// - Relative byte 31h returns 20h, the uniform 4-KB sector erase opcode.
// - Relative byte 32h returns F1h: 1-1-4, 1-4-4, 1-2-2, 1-1-2 reads, 3-byte address.
// - Relative byte 33h returns FFh, the unused top byte of doubleword one.
// - Bytes 34h..37h hold density minus one, LSB first: FFh, FFh, FFh, 00h.
// - Relative byte 38h returns 44h: quad I/O read, two mode, four dummy cycles.
// - Relative byte 39h returns EBh, the quad I/O read opcode.
// - Relative byte 3Ah returns 08h: quad output read, no mode, eight dummy cycles.
// - Relative byte 3Bh returns 6Bh, the quad output read opcode.
// - Relative byte 3Ch returns 08h: dual output read, no mode, eight dummy cycles.
// - Relative byte 3Dh returns 3Bh, the dual output read opcode.
// - Relative byte 3Eh returns 80h: dual I/O read, four mode, zero dummy cycles.
// - The basic table starts at offset 30h; header zero points there.
// - Header zero reports the basic table length as 10h doublewords.
package sfdp_pkg;

  // Serial framing
  localparam logic [7:0] OP_READ_PARAM = 8'h5A;
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [4:0] DUMMY_LAST = 5'h07;

  // Parameter space contents
  localparam logic [23:0] ADDR_HDR_LENGTH = 24'h00000B;
  localparam logic [23:0] ADDR_HDR_POINTER = 24'h00000C;
  localparam logic [7:0] HDR_LENGTH_DWORDS = 8'h10;
  localparam logic [7:0] TABLE_BASE = 8'h30;
  localparam logic [23:0] ADDR_ERASE_INFO = 24'h000030;
  localparam logic [23:0] ADDR_ERASE_OP = 24'h000031;
  localparam logic [23:0] ADDR_READ_SUPPORT = 24'h000032;
  localparam logic [23:0] ADDR_DW1_TOP = 24'h000033;
  localparam logic [23:0] ADDR_DENSITY_B0 = 24'h000034;
  localparam logic [23:0] ADDR_DENSITY_B1 = 24'h000035;
  localparam logic [23:0] ADDR_DENSITY_B2 = 24'h000036;
  localparam logic [23:0] ADDR_DENSITY_B3 = 24'h000037;
  localparam logic [23:0] ADDR_QUAD_IO_READ_CYCLES = 24'h000038;
  localparam logic [23:0] ADDR_QUAD_IO_READ_OP = 24'h000039;
  localparam logic [23:0] ADDR_QUAD_OUTPUT_READ_CYCLES = 24'h00003A;
  localparam logic [23:0] ADDR_QUAD_OUTPUT_READ_OP = 24'h00003B;
  localparam logic [23:0] ADDR_DUAL_OUTPUT_READ_CYCLES = 24'h00003C;
  localparam logic [23:0] ADDR_DUAL_OUTPUT_READ_OP = 24'h00003D;
  localparam logic [23:0] ADDR_DUAL_IO_READ_CYCLES = 24'h00003E;
  localparam logic [7:0] VAL_ERASE_INFO = 8'hE5;
  localparam logic [7:0] VAL_ERASE_OP = 8'h20;
  localparam logic [7:0] VAL_READ_SUPPORT = 8'hF1;
  localparam logic [7:0] VAL_ALL_ONES = 8'hFF;
  localparam logic [7:0] VAL_DENSITY_TOP = 8'h00;
  localparam logic [7:0] VAL_QUAD_IO_READ_CYCLES = 8'h44;
  localparam logic [7:0] VAL_QUAD_IO_READ_OP = 8'hEB;
  localparam logic [7:0] VAL_QUAD_OUTPUT_READ_CYCLES = 8'h08;
  localparam logic [7:0] VAL_QUAD_OUTPUT_READ_OP = 8'h6B;
  localparam logic [7:0] VAL_DUAL_OUTPUT_READ_CYCLES = 8'h08;
  localparam logic [7:0] VAL_DUAL_OUTPUT_READ_OP = 8'h3B;
  localparam logic [7:0] VAL_DUAL_IO_READ_CYCLES = 8'h80;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LOOKUP_ADDR = 8'h08;
  localparam logic [7:0] REG_LOOKUP_DATA = 8'h0C;
  localparam logic [7:0] REG_BYTE_COUNT = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam int STATUS_ACTIVE_BIT = 0;
  localparam int STATUS_STATE_LSB = 1;
  localparam int STATUS_ADDR_LSB = 8;
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DATA = 3'h6,
    ST_IGNORE = 3'h7
  } link_state_t;

  typedef struct packed
  {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spi_in_t;

  typedef struct packed
  {
    logic sel;
    logic write;
    logic [7:0] addr;
  } bus_req_t;

endpackage

// File: sfdp_rom_assertions.sv
/*
  Concurrent checks for the parameter ROM: bus wait state, serial output enable
  and table bytes read back through the lookup registers.
  Assumes one AHB-Lite master, with hready fed from hreadyout.
*/
module sfdp_rom_assertions
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire sfdp_pkg::spi_in_t spi_in,
  input wire logic miso_oe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  localparam logic [119:0] TAB = 120'h803B086B08EB4400FFFFFFFFF120E5;
  logic rd_dp;
  logic wr_dp;
  logic [7:0] dp_addr;
  logic [7:0] lut_addr;
  wire ap = ce & hsel & hready & htrans[1];
  wire lut_rd = rd_dp & hready & (dp_addr == sfdp_pkg::REG_LOOKUP_DATA);
  wire [7:0] got = hrdata[7:0];
  wire [7:0] want = TAB[8 * (lut_addr - 8'h30) +: 8];

  // Shadow of the lookup address, so read data can be tied to its cause
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rd_dp <= 1'h0;
      wr_dp <= 1'h0;
      dp_addr <= 8'h00;
      lut_addr <= 8'h00;
    end
    else if (ce && hready)
    begin
      rd_dp <= ap & ~hwrite;
      wr_dp <= ap & hwrite;
      dp_addr <= haddr[7:0];
      if (wr_dp && dp_addr == sfdp_pkg::REG_LOOKUP_ADDR)
        lut_addr <= hwdata[7:0];
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  a_resp_okay: assert property (hresp == 1'h0) else $error("error response");
  a_read_wait: assert property (ap && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_oe_idle: assert property (spi_in.cs_n [*5] |-> !miso_oe) else $error("drives while deselected");
  a_oe_framed: assert property ($rose(miso_oe) |-> !spi_in.cs_n) else $error("enable outside frame");
  a_header_len: assert property (lut_rd && lut_addr == 8'h0B |-> got == 8'h10)
    else $error("bad table length");
  a_header_ptr: assert property (lut_rd && lut_addr == 8'h0C |-> got == 8'h30)
    else $error("bad table pointer");
  a_dword_one: assert property (lut_rd && lut_addr inside {[8'h30:8'h33]} |-> got == want)
    else $error("bad first dword");
  a_density: assert property (lut_rd && lut_addr inside {[8'h34:8'h37]} |-> got == want)
    else $error("bad density");
  a_quad_read: assert property (lut_rd && lut_addr inside {[8'h38:8'h3B]} |-> got == want)
    else $error("bad quad fields");
  a_dual_read: assert property (lut_rd && lut_addr inside {[8'h3C:8'h3E]} |-> got == want)
    else $error("bad dual fields");

  c_lut_read: cover property (lut_rd);
  c_write: cover property (ap && hwrite);
  c_oe_on: cover property ($rose(miso_oe));
endmodule

bind sfdp_basic_param_rom sfdp_rom_assertions sfdp_rom_assertions_i
(.clk(clk), .reset(reset), .ce(ce), .spi_in(spi_in), .miso_oe(miso_oe), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata));

// File: spi_host_model.sv
/*
  Host controller model for the parameter-read link: mode 0, MSB first.
  Assumes one frame at a time; the 80 ns serial clock stands low between frames.
*/
module spi_host_model
(
  output sfdp_pkg::spi_in_t spi_in,
  input wire logic miso_o,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx [0:15];
  logic oe_any;

  initial
    spi_in = 3'h2;

  // Samples just before the fall: the device output lags each fall by a few clk
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n);
    logic [39:0] cmd;
    cmd = {op, a, 8'hFF};
    oe_any = 1'h0;
    spi_in.cs_n = 1'h0;
    #100;
    for (int i = 39; i >= 0; i--)
    begin
      spi_in.mosi = cmd[i];
      #40 spi_in.sclk = 1'h1;
      #40 spi_in.sclk = 1'h0;
    end
    for (int b = 0; b < n; b++)
      for (int i = 7; i >= 0; i--)
      begin
        #40 spi_in.sclk = 1'h1;
        #38 rx[b][i] = miso_oe ? miso_o : ~miso_o;
        oe_any = oe_any | miso_oe;
        #2 spi_in.sclk = 1'h0;
      end
    #40 spi_in.cs_n = 1'h1;
    #100;
  endtask
endmodule

// File: tb_top.sv
/*
  Bench: AHB-Lite master tasks, lookup sweep and serial table reads.
  Assumes the host model drives the link and the ROM is the only bus slave.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [119:0] TAB = 120'h803B086B08EB4400FFFFFFFFF120E5;
  logic clk, reset, ce, hsel, hwrite, hreadyout, hresp, miso_o, miso_oe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  sfdp_pkg::spi_in_t spi_in;
  int num_errors;
  int n_tests;

  spi_host_model spi_host_model_i (.spi_in(spi_in), .miso_o(miso_o), .miso_oe(miso_oe));
  sfdp_basic_param_rom sfdp_basic_param_rom_i
  (.clk(clk), .reset(reset), .ce(ce), .spi_in(spi_in), .miso_o(miso_o), .miso_oe(miso_oe), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    if (a == 8'h0B)
      return 8'h10;
    if (a == 8'h0C)
      return 8'h30;
    if (a >= 8'h30 && a <= 8'h3E)
      return TAB[8 * (a - 8'h30) +: 8];
    return 8'hFF;
  endfunction

  task automatic test_done();
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      num_errors++;
      $display("MISMATCH at %0t seen %h want %h", $time, seen, want);
    end
  endtask

  // Ready and read data are taken at the rising edge, before that edge's updates land
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    for (int p = 0; p < 2; p++)
    begin
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (hreadyout !== 1'h1 && k < 20);
      if (hreadyout !== 1'h1)
      begin
        num_errors++;
        test_done();
      end
      if (p == 0)
      begin
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
      end
      else
      begin
        rd = hrdata;
      end
    end
  endtask

  task automatic sframe(input logic [7:0] op, input logic [23:0] a, input int n);
    // Pins move on falling clk edges, away from the synchroniser's sampling edge
    @(negedge clk);
    spi_host_model_i.frame(op, a, n);
    @(posedge clk);
  endtask

  initial
  begin
    reset = 1'h1;
    ce = 1'h1;
    hsel = 1'h0;
    hwrite = 1'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    bus(1'h1, 8'h20, 32'hFFFFFFFF);
    bus(1'h0, 8'h20, 32'h0);
    check(rd, 32'h0);
    for (int a = 8'h0B; a <= 8'h3E; a++)
    begin
      bus(1'h1, sfdp_pkg::REG_LOOKUP_ADDR, 32'(a));
      bus(1'h1, sfdp_pkg::REG_LOOKUP_DATA, 32'h000000A5);
      bus(1'h0, sfdp_pkg::REG_LOOKUP_DATA, 32'h0);
      check(rd, {24'h0, exp_byte(8'(a))});
    end
    bus(1'h0, sfdp_pkg::REG_LOOKUP_ADDR, 32'h0);
    check(rd, 32'h0000003E);
    sframe(sfdp_pkg::OP_READ_PARAM, 24'h00000B, 2);
    check({24'h0, spi_host_model_i.rx[0]}, 32'h10);
    check({24'h0, spi_host_model_i.rx[1]}, 32'h30);
    sframe(sfdp_pkg::OP_READ_PARAM, {16'h0000, spi_host_model_i.rx[1]}, 15);
    for (int i = 0; i < 15; i++)
      check({24'h0, spi_host_model_i.rx[i]}, {24'h0, exp_byte(8'h30 + 8'(i))});
    check({31'h0, spi_host_model_i.oe_any}, 32'h1);
    sframe(8'h03, 24'h000030, 2);
    check({31'h0, spi_host_model_i.oe_any}, 32'h0);
    bus(1'h1, sfdp_pkg::REG_CTRL, 32'h0);
    sframe(sfdp_pkg::OP_READ_PARAM, 24'h000030, 2);
    check({31'h0, spi_host_model_i.oe_any}, 32'h0);
    bus(1'h1, sfdp_pkg::REG_CTRL, 32'h1);
    bus(1'h0, sfdp_pkg::REG_CTRL, 32'h0);
    check(rd, 32'h00000001);
    // Idle, deselected, next data address 40h after the sixteen bytes begun from 30h
    bus(1'h0, sfdp_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h00004000);
    // Each enabled frame also begins one byte on its closing serial fall: 3 + 16
    bus(1'h0, sfdp_pkg::REG_BYTE_COUNT, 32'h0);
    check(rd, 32'h00000013);
    test_done();
  end
endmodule
